// ==== rtl/infoframe_bar_audio_readback.sv ====
// Purpose: Read-only bank of captured bar positions, audio fields and
//          packet change flags, reached over AHB-Lite
// Assumes: Packet receiver runs on hclk; registers are byte wide in the
//          low lane of a word, byte address = index * 4
// Notes:   Zero wait states; writes and unmapped reads answer OKAY
//          Read data is taken in the address phase and shown in the data phase
//          Addresses above the bank and unmapped indices read as zero
//          hsize and hwdata are accepted and left unused
//          A flag read clears every flag bit; a flag set on that edge survives
//          Bar halves are read one byte at a time and are not held as a pair,
//          so a capture between the two reads can tear a 16-bit value
//          Bar and audio change flags rise only on new content, not on every
//          repeat of an unchanged frame
//          Bar-absent outputs follow the held positions one cycle later
//
// How it works
// - Flag bits 2..6 mark descriptor, MPEG source, ACP, ISRC1, ISRC2 changes
// - Top-bar end high byte at index 0x88, joins low byte as 16 bits
// - Lower bar first line 16 bits at 0x89/0x8A; over line count means none
// - Left bar last pixel 16 bits at 0x8B/0x8C; zero means no left bar
// - Right bar first pixel 16 bits at 0x8D/0x8E; over width means none
// - Index 0x8F returns the same seven flag bits as other flag locations
// - Audio format code sits in bits 7..4 of index 0x91
// - Audio channel total sits in bits 2..0 of index 0x91
// - Reading any flag location clears all flags; new events still win
// - A changed packet of a type sets that type's flag bit
// - Top-bar end of zero means no top bar; low byte at index 0x86
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "infoframe_readback_params.svh"

module infoframe_bar_audio_readback
  import infoframe_readback_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        avi_capture_valid,
  input  wire logic [15:0] top_bar_end_in,
  input  wire logic [15:0] bottom_bar_start_in,
  input  wire logic [15:0] left_bar_end_in,
  input  wire logic [15:0] right_bar_start_in,
  input  wire logic        audio_capture_valid,
  input  wire logic [7:0]  audio_frame_version_in,
  input  wire logic [3:0]  audio_format_code_in,
  input  wire logic [2:0]  audio_channel_total_in,
  input  wire logic [4:0]  other_packet_changed,
  input  wire logic [15:0] active_line_total,
  input  wire logic [15:0] active_pixel_total,
  output logic             no_top_bar,
  output logic             no_bottom_bar,
  output logic             no_left_bar,
  output logic             no_right_bar
);

  // Captured fields
  bar_pos_t      top_bar_end_r;
  bar_pos_t      bottom_bar_start_r;
  bar_pos_t      left_bar_end_r;
  bar_pos_t      right_bar_start_r;
  reg_byte_t     audio_frame_version_r;
  audio_format_t audio_format_code_r;
  audio_chan_t   audio_channel_total_r;
  change_flags_t packet_change_flag_r;
  change_flags_t flag_set;

  // Bus decode
  reg_index_t    addr_idx;
  logic          addr_in_range;
  logic          rd_take;
  logic          flag_read;
  reg_byte_t     rd_byte;
  logic          avi_differs;
  logic          audio_differs;
  logic [31:0]   hrdata_r;
  logic [2:0]    unused_size;
  logic [31:0]   unused_wdata;
  logic          xfer_take;

  // Change detection
  logic          top_changed;
  logic          bottom_changed;
  logic          left_changed;
  logic          right_changed;
  logic          version_changed;
  logic          format_changed;
  logic          channels_changed;

  // True when the index is one of the three flag locations
  function automatic logic is_flag_index(input reg_index_t idx);
    is_flag_index = (idx == `IDX_CHANGE_FLAGS_A) ||
                    (idx == `IDX_CHANGE_FLAGS_MIRROR) ||
                    (idx == `IDX_CHANGE_FLAGS_B);
  endfunction : is_flag_index

  // Low or high byte of a 16-bit bar position
  function automatic reg_byte_t bar_byte(input bar_pos_t pos, input logic high);
    bar_byte = high ? pos[15:8] : pos[7:0];
  endfunction : bar_byte

  // Flag word in the low bits of a byte, unused top bit zero
  function automatic reg_byte_t flag_byte(input change_flags_t flags);
    reg_byte_t b;
    b = `RST_BYTE;
    b[`FLAG_COUNT-1:0] = flags;
    flag_byte = b;
  endfunction : flag_byte

  // Audio format code over channel total; bit 3 reads zero
  function automatic reg_byte_t audio_byte(
    input audio_format_t fmt,
    input audio_chan_t   chan
  );
    reg_byte_t b;
    b = `RST_BYTE;
    b[`AUD_FORMAT_MSB:`AUD_FORMAT_LSB] = fmt;
    b[`AUD_CHAN_MSB:`AUD_CHAN_LSB]     = chan;
    audio_byte = b;
  endfunction : audio_byte

  // Read data for one index; unmapped indices read zero
  function automatic reg_byte_t read_mux(
    input reg_index_t    idx,
    input bar_pos_t      top_v,
    input bar_pos_t      bot_v,
    input bar_pos_t      left_v,
    input bar_pos_t      right_v,
    input reg_byte_t     ver_v,
    input audio_format_t fmt_v,
    input audio_chan_t   chan_v,
    input change_flags_t flags_v
  );
    reg_byte_t b;
    b = `RST_BYTE;
    if (is_flag_index(idx)) begin
      b = flag_byte(flags_v);
    end else begin
      unique case (idx)
        `IDX_TOP_BAR_END_LOW:  b = bar_byte(top_v, 1'b0);
        `IDX_TOP_BAR_END_HIGH: b = bar_byte(top_v, 1'b1);
        `IDX_BOTTOM_BAR_LOW:   b = bar_byte(bot_v, 1'b0);
        `IDX_BOTTOM_BAR_HIGH:  b = bar_byte(bot_v, 1'b1);
        `IDX_LEFT_BAR_LOW:     b = bar_byte(left_v, 1'b0);
        `IDX_LEFT_BAR_HIGH:    b = bar_byte(left_v, 1'b1);
        `IDX_RIGHT_BAR_LOW:    b = bar_byte(right_v, 1'b0);
        `IDX_RIGHT_BAR_HIGH:   b = bar_byte(right_v, 1'b1);
        `IDX_AUDIO_VERSION:    b = ver_v;
        `IDX_AUDIO_FORMAT:     b = audio_byte(fmt_v, chan_v);
        default:               b = `RST_BYTE;
      endcase
    end
    read_mux = b;
  endfunction : read_mux

  assign unused_size  = hsize;
  assign unused_wdata = hwdata;

  assign addr_idx      = haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
  assign addr_in_range = (haddr[31:`ADDR_TOP_LSB] == '0);

  // Writes take no action anywhere in this bank
  assign xfer_take = hsel && hready && htrans[`HTRANS_BUSY_IDLE_BIT];
  assign rd_take   = xfer_take && !hwrite;
  assign flag_read = rd_take && addr_in_range && is_flag_index(addr_idx);

  assign rd_byte = addr_in_range ?
                   read_mux(addr_idx, top_bar_end_r, bottom_bar_start_r,
                            left_bar_end_r, right_bar_start_r,
                            audio_frame_version_r, audio_format_code_r,
                            audio_channel_total_r, packet_change_flag_r) :
                   `RST_BYTE;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = `HRESP_OKAY;
  assign hrdata    = hrdata_r;

  // Read data is latched at the address phase for the data phase
  // and stands until the next read is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= `RST_WORD32;
    end else if (rd_take) begin
      hrdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // Per-field comparison against what is held; a repeated frame with the
  // same content must not raise its change flag
  assign top_changed    = (top_bar_end_in      != top_bar_end_r);
  assign bottom_changed = (bottom_bar_start_in != bottom_bar_start_r);
  assign left_changed   = (left_bar_end_in     != left_bar_end_r);
  assign right_changed  = (right_bar_start_in  != right_bar_start_r);

  assign avi_differs = top_changed    ||
                       bottom_changed ||
                       left_changed   ||
                       right_changed;

  assign version_changed  = (audio_frame_version_in != audio_frame_version_r);
  assign format_changed   = (audio_format_code_in   != audio_format_code_r);
  assign channels_changed = (audio_channel_total_in != audio_channel_total_r);

  assign audio_differs = version_changed ||
                         format_changed  ||
                         channels_changed;

  // Top bar end line; zero means no top bar
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      top_bar_end_r <= `RST_WORD16;
    end else if (avi_capture_valid) begin
      top_bar_end_r <= top_bar_end_in;
    end
  end

  // Bottom bar first line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bottom_bar_start_r <= `RST_WORD16;
    end else if (avi_capture_valid) begin
      bottom_bar_start_r <= bottom_bar_start_in;
    end
  end

  // Left bar last pixel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_bar_end_r <= `RST_WORD16;
    end else if (avi_capture_valid) begin
      left_bar_end_r <= left_bar_end_in;
    end
  end

  // Right bar first pixel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      right_bar_start_r <= `RST_WORD16;
    end else if (avi_capture_valid) begin
      right_bar_start_r <= right_bar_start_in;
    end
  end

  // Audio frame version
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      audio_frame_version_r <= `RST_BYTE;
    end else if (audio_capture_valid) begin
      audio_frame_version_r <= audio_frame_version_in;
    end
  end

  // Audio format code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      audio_format_code_r <= '0;
    end else if (audio_capture_valid) begin
      audio_format_code_r <= audio_format_code_in;
    end
  end

  // Audio channel total
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      audio_channel_total_r <= '0;
    end else if (audio_capture_valid) begin
      audio_channel_total_r <= audio_channel_total_in;
    end
  end

  // Per-type change events; the bar and audio flags need a capture
  // whose content differs from what is held
  assign flag_set[`FLAG_AVI]   = avi_capture_valid && avi_differs;
  assign flag_set[`FLAG_AUDIO] = audio_capture_valid && audio_differs;

  genvar g;
  generate
    for (g = 0; g < `FLAG_OTHER_COUNT; g++) begin : g_other
      assign flag_set[`FLAG_OTHER_LSB + g] = other_packet_changed[g];
    end

    // A set in the same cycle as a clearing read survives, so an event
    // that lands on the read edge is reported by the next read
    for (g = 0; g < `FLAG_COUNT; g++) begin : g_flag
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          packet_change_flag_r[g] <= 1'b0;
        end else if (flag_set[g]) begin
          packet_change_flag_r[g] <= 1'b1;
        end else if (flag_read) begin
          packet_change_flag_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Top bar absent when its end line is zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      no_top_bar <= 1'b1;
    end else begin
      no_top_bar <= (top_bar_end_r == `RST_WORD16);
    end
  end

  // Bottom bar absent when it starts past the last active line;
  // a start equal to the line total still counts as a bar
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      no_bottom_bar <= 1'b1;
    end else begin
      no_bottom_bar <= (bottom_bar_start_r > active_line_total);
    end
  end

  // Left bar absent when its last pixel is zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      no_left_bar <= 1'b1;
    end else begin
      no_left_bar <= (left_bar_end_r == `RST_WORD16);
    end
  end

  // Right bar absent when it starts past the last pixel;
  // a start equal to the pixel total still counts as a bar
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      no_right_bar <= 1'b1;
    end else begin
      no_right_bar <= (right_bar_start_r > active_pixel_total);
    end
  end

endmodule : infoframe_bar_audio_readback
`default_nettype wire

// ==== rtl/infoframe_readback_params.svh ====
// Purpose: Constants for the infoframe bar and audio readback bank
// Assumes: Register byte address is four times the register index
// Notes:   Included by the package and the bank
`ifndef INFOFRAME_READBACK_PARAMS_SVH
`define INFOFRAME_READBACK_PARAMS_SVH

// Register indices (byte address = index * 4)
`define IDX_TOP_BAR_END_LOW      8'h86
`define IDX_CHANGE_FLAGS_A       8'h87
`define IDX_TOP_BAR_END_HIGH     8'h88
`define IDX_BOTTOM_BAR_LOW       8'h89
`define IDX_BOTTOM_BAR_HIGH      8'h8A
`define IDX_LEFT_BAR_LOW         8'h8B
`define IDX_LEFT_BAR_HIGH        8'h8C
`define IDX_RIGHT_BAR_LOW        8'h8D
`define IDX_RIGHT_BAR_HIGH       8'h8E
`define IDX_CHANGE_FLAGS_MIRROR  8'h8F
`define IDX_AUDIO_VERSION        8'h90
`define IDX_AUDIO_FORMAT         8'h91
`define IDX_CHANGE_FLAGS_B       8'h97

// Address layout on the bus
`define ADDR_IDX_LSB             2
`define ADDR_IDX_MSB             9
`define ADDR_TOP_LSB             10

// Flag bit positions
`define FLAG_AVI                 0
`define FLAG_AUDIO               1
`define FLAG_OTHER_LSB           2
`define FLAG_COUNT               7
`define FLAG_OTHER_COUNT         5

// Field layout of the audio format register
`define AUD_FORMAT_LSB           4
`define AUD_FORMAT_MSB           7
`define AUD_CHAN_LSB             0
`define AUD_CHAN_MSB             2

// Reset values
`define RST_BYTE                 8'h00
`define RST_WORD16               16'h0000
`define RST_FLAGS                7'h00
`define RST_WORD32               32'h0000_0000

// AHB encodings
`define HTRANS_BUSY_IDLE_BIT     1
`define HRESP_OKAY               1'b0

`endif

// ==== rtl/infoframe_readback_pkg.sv ====
// Purpose: Shared types for the infoframe bar and audio readback bank
// Assumes: Constants come from the params header
// Notes:   Types only; flag and index widths come from the header, other widths are fixed here
`include "infoframe_readback_params.svh"

package infoframe_readback_pkg;

  typedef logic [7:0]                   reg_byte_t;
  typedef logic [15:0]                  bar_pos_t;
  typedef logic [`FLAG_COUNT-1:0]       change_flags_t;
  typedef logic [`ADDR_IDX_MSB-`ADDR_IDX_LSB:0] reg_index_t;
  typedef logic [3:0]                   audio_format_t;
  typedef logic [2:0]                   audio_chan_t;

endpackage : infoframe_readback_pkg

// ==== test/infoframe_bar_audio_readback_tb.sv ====
// Purpose: Self-checking bench for the infoframe readback bank
// Assumes: Host model drives the bus, bench drives the capture side
// Notes:   Bar values chosen to hit absent and present cases
`timescale 1ns/10ps
`default_nettype none
module infoframe_bar_audio_readback_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, avi_v = 1'b0, aud_v = 1'b0, rdy, hresp, hsel, hwrite;
  logic        stuck;
  logic [15:0] top = '0, bot = '0, lft = '0, rgt = '0;
  logic [7:0]  ver = '0;
  logic [3:0]  fmt = '0;
  logic [2:0]  chn = '0, hsize;
  logic [4:0]  oth = '0;
  logic [3:0]  absent;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  int          num_errors = 0, num_checks = 0;
  logic [7:0]  bar_exp [10] = '{8'h34, 8'h01, 8'h12, 8'h56, 8'h04, 8'h00, 8'h00, 8'h89, 8'h07, 8'h00};
  initial forever #5 hclk = ~hclk;
  infoframe_host_model host_u (.hclk, .hready(rdy), .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .timed_out(stuck));
  infoframe_bar_audio_readback dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(rdy), .hreadyout(rdy), .hresp, .hrdata, .avi_capture_valid(avi_v),
    .top_bar_end_in(top), .bottom_bar_start_in(bot), .left_bar_end_in(lft),
    .right_bar_start_in(rgt), .audio_capture_valid(aud_v), .audio_frame_version_in(ver),
    .audio_format_code_in(fmt), .audio_channel_total_in(chn), .other_packet_changed(oth),
    .active_line_total(16'h0400), .active_pixel_total(16'h0780), .no_top_bar(absent[3]),
    .no_bottom_bar(absent[2]), .no_left_bar(absent[1]), .no_right_bar(absent[0]));
  task automatic tally_and_finish;
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic chk(input logic [7:0] ix, input logic [7:0] e);
    host_u.xfer(1'b0, {22'h0, ix, 2'b00}, d);
    cmp(d, {24'h0, e});
  endtask : chk
  task automatic avi(input logic [15:0] t, input logic [15:0] b, input logic [15:0] l,
                     input logic [15:0] r);
    {top, bot, lft, rgt, avi_v} <= {t, b, l, r, 1'b1};
    @(posedge hclk);
    avi_v <= 1'b0;
  endtask : avi
  always @(posedge hclk) begin
    if (stuck) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(8'h88, 8'h00);
    avi(16'h1234, 16'h0456, 16'h0000, 16'h0789);
    for (int i = 0; i < 10; i++)
      chk(8'h86 + 8'(i), bar_exp[i]);
    cmp({28'h0, absent}, 32'h7);
    avi(16'h0000, 16'h0100, 16'h0020, 16'h0100);
    chk(8'h8F, 8'h01);
    cmp({28'h0, absent}, 32'h8);
    for (int k = 0; k < 5; k++) begin
      oth <= 5'(1 << k);
      @(posedge hclk);
      oth <= 5'h00;
      chk(8'h97, 8'(4 << k));
    end
    chk(8'h97, 8'h00);
    for (int c = 0; c < 9; c++) begin
      {ver, fmt, chn, aud_v} <= {8'(8'h10 + c), 4'(c), 3'(c), 1'b1};
      @(posedge hclk);
      aud_v <= 1'b0;
      chk(8'h90, 8'(8'h10 + c));
      chk(8'h91, {4'(c), 1'b0, 3'(c)});
      chk(8'h87, 8'h02);
    end
    host_u.xfer(1'b1, 32'h0000_0240, d);
    chk(8'h90, 8'h18);
    chk(8'h8E, 8'h01);
    host_u.xfer(1'b0, 32'h0000_1240, d);
    cmp(d, 32'h0);
    tally_and_finish();
  end
endmodule : infoframe_bar_audio_readback_tb
`default_nettype wire

// ==== test/infoframe_host_model.sv ====
// Purpose: Host processor issuing single AHB-Lite word transfers
// Assumes: Called right after a rising edge
// Notes:   Write data is the inverted address so the lane is never idle-looking
`timescale 1ns/10ps
`default_nettype none
module infoframe_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  output var  logic        timed_out
);
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata, timed_out} = '0;
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (!hready && n < 64);
    if (!hready)
      timed_out <= 1'b1;
  endtask : wait_ready
  task automatic xfer(input logic w, input logic [31:0] a, output logic [31:0] d);
    {hsel, haddr, hwrite, htrans, hsize} <= {1'b1, a, w, 2'b10, 3'b010};
    wait_ready();
    {htrans, hwdata} <= {2'b00, ~a};
    wait_ready();
    d = hrdata;
  endtask : xfer
endmodule : infoframe_host_model
`default_nettype wire

// ==== test/infoframe_readback_monitor.sv ====
// Purpose: Property checks on the readback bank ports
// Assumes: One clock, asynchronous active-low reset
// Notes:   Attached to the bank by bind
`timescale 1ns/10ps
`default_nettype none
module infoframe_readback_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        avi_capture_valid,
  input wire logic        audio_capture_valid,
  input wire logic [4:0]  other_packet_changed,
  input wire logic [15:0] top_bar_end_in,
  input wire logic [15:0] left_bar_end_in,
  input wire logic        no_top_bar,
  input wire logic        no_left_bar
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic       rd    = hsel && hready && htrans[1] && !hwrite;
  wire logic [7:0] ix    = haddr[9:2];
  wire logic       rd_nf = rd && haddr[31:10] == 22'h0 && (ix == 8'h87 || ix == 8'h8F || ix == 8'h97);
  wire logic       quiet = !avi_capture_valid && !audio_capture_valid && other_packet_changed == 5'h00;
  sequence s_desc_read;
    other_packet_changed[0] ##1 rd_nf;
  endsequence
  sequence s_top_zero_cap;
    avi_capture_valid && top_bar_end_in == 16'h0000 ##1 !avi_capture_valid;
  endsequence
  sequence s_left_set_cap;
    avi_capture_valid && left_bar_end_in != 16'h0000 ##1 !avi_capture_valid;
  endsequence
  sequence s_isrc2_read;
    other_packet_changed[4] ##1 rd_nf;
  endsequence
  sequence s_quiet_reread;
    rd_nf && quiet ##1 quiet ##1 rd_nf;
  endsequence
  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus stall or error response");
  a_flag_upper_zero: assert property (rd_nf |=> hrdata[31:7] == 25'h0)
    else $error("flag read has bits above six set");
  a_desc_flag_set: assert property (s_desc_read |=> hrdata[2])
    else $error("descriptor change not in flag bit two");
  a_isrc2_flag_set: assert property (s_isrc2_read |=> hrdata[6])
    else $error("second track code change not in flag bit six");
  a_flag_read_clears: assert property (s_quiet_reread |=> hrdata[7:0] == 8'h00)
    else $error("flags not cleared by previous read");
  a_top_zero_absent: assert property (s_top_zero_cap |=> no_top_bar)
    else $error("zero top bar not flagged absent");
  a_left_set_present: assert property (s_left_set_cap |=> !no_left_bar)
    else $error("nonzero left bar flagged absent");
  a_unmapped_reads_zero: assert property (rd && haddr[31:10] != 22'h0 |=> hrdata == 32'h0)
    else $error("unmapped read returned data");
endmodule : infoframe_readback_monitor
bind infoframe_bar_audio_readback infoframe_readback_monitor mon_u (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .avi_capture_valid,
  .audio_capture_valid, .other_packet_changed, .top_bar_end_in, .left_bar_end_in, .no_top_bar,
  .no_left_bar);
`default_nettype wire
